/* rtl/cise_pkg.sv */
package cise_pkg;

    // Register offsets (byte addresses)
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_ACC     = 12'h008;
    localparam logic [11:0] REG_IDX     = 12'h00c;
    localparam logic [11:0] REG_SP      = 12'h010;
    localparam logic [11:0] REG_CC      = 12'h014;
    localparam logic [11:0] REG_PC      = 12'h018;

    // Field positions
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_STEP_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ERR_BIT  = 1;
    localparam int CC_C = 0;
    localparam int CC_Z = 1;
    localparam int CC_N = 2;
    localparam int CC_I = 3;
    localparam int CC_H = 4;

    // Reset values
    localparam logic [7:0] SP_TOP = 8'h7f;
    localparam logic [4:0] CC_RST = 5'h08;

    // Addressing-mode nibble (opcode bits 7:4)
    localparam logic [3:0] M_RMW_DIR = 4'h3;
    localparam logic [3:0] M_ACC     = 4'h4;
    localparam logic [3:0] M_IDX     = 4'h5;
    localparam logic [3:0] M_RMW_IX1 = 4'h6;
    localparam logic [3:0] M_RMW_IX  = 4'h7;
    localparam logic [3:0] M_IMM     = 4'ha;
    localparam logic [3:0] M_DIR     = 4'hb;
    localparam logic [3:0] M_EXT     = 4'hc;
    localparam logic [3:0] M_IX2     = 4'hd;
    localparam logic [3:0] M_IX1     = 4'he;
    localparam logic [3:0] M_IX      = 4'hf;

    // Operation nibble (opcode bits 3:0)
    localparam logic [3:0] F_NEG = 4'h0;
    localparam logic [3:0] F_LSR = 4'h4;
    localparam logic [3:0] F_ROR = 4'h6;
    localparam logic [3:0] F_LSL = 4'h8;
    localparam logic [3:0] F_ROL = 4'h9;
    localparam logic [3:0] F_LDA = 4'h6;
    localparam logic [3:0] F_ORA = 4'ha;
    localparam logic [3:0] F_JSR = 4'hd;
    localparam logic [3:0] F_LDX = 4'he;

    localparam logic [7:0] OPC_RTI = 8'h80;
    localparam logic [7:0] OPC_RSP = 8'h9c;
    localparam logic [7:0] OPC_NOP = 8'h9d;

    // Documented cycle counts, a floor for each instruction
    localparam logic [2:0] CYC_INH     = 3'h1;
    localparam logic [2:0] CYC_RTI     = 3'h7;
    localparam logic [2:0] CYC_RMW_DIR = 3'h4;
    localparam logic [2:0] CYC_RMW_IX  = 3'h3;
    localparam logic [2:0] CYC_RMW_IX1 = 3'h5;
    localparam logic [2:0] CYC_IMM     = 3'h2;
    localparam logic [2:0] CYC_DIR     = 3'h3;
    localparam logic [2:0] CYC_EXT     = 3'h4;
    localparam logic [2:0] CYC_IX      = 3'h2;
    localparam logic [2:0] CYC_IX1     = 3'h4;
    localparam logic [2:0] CYC_IX2     = 3'h5;
    localparam logic [2:0] CYC_JSR_DIR = 3'h4;
    localparam logic [2:0] CYC_JSR_EXT = 3'h5;
    localparam logic [2:0] CYC_JSR_IX  = 3'h3;
    localparam logic [2:0] CYC_JSR_IX1 = 3'h4;
    localparam logic [2:0] CYC_JSR_IX2 = 3'h5;

    typedef enum logic [2:0] {
        ALU_PASS, ALU_OR, ALU_NEG, ALU_LSL, ALU_LSR, ALU_ROL, ALU_ROR
    } cise_alu_t;

    typedef enum {
        ST_IDLE, ST_FETCH, ST_RWAIT, ST_OPC, ST_BYTE2, ST_BYTE3,
        ST_EXEC, ST_DATA, ST_PUSH_HI, ST_PULL, ST_DONE
    } cise_state_t;

    function automatic logic [2:0] cise_cycles(input logic [7:0] opc);
        logic call_subroutine;
        call_subroutine = (opc[3:0] == F_JSR);
        case (opc[7:4])
            M_ACC, M_IDX, 4'h9: cise_cycles = CYC_INH;
            M_RMW_DIR:          cise_cycles = CYC_RMW_DIR;
            M_RMW_IX:           cise_cycles = CYC_RMW_IX;
            M_RMW_IX1:          cise_cycles = CYC_RMW_IX1;
            4'h8:               cise_cycles = CYC_RTI;
            M_IMM:              cise_cycles = CYC_IMM;
            M_DIR:              cise_cycles = call_subroutine ? CYC_JSR_DIR : CYC_DIR;
            M_EXT:              cise_cycles = call_subroutine ? CYC_JSR_EXT : CYC_EXT;
            M_IX2:              cise_cycles = call_subroutine ? CYC_JSR_IX2 : CYC_IX2;
            M_IX1:              cise_cycles = call_subroutine ? CYC_JSR_IX1 : CYC_IX1;
            M_IX:               cise_cycles = call_subroutine ? CYC_JSR_IX : CYC_IX;
            default:            cise_cycles = CYC_INH;
        endcase
    endfunction : cise_cycles

endpackage : cise_pkg

/* rtl/cise_alu.sv */
`timescale 1ns/100ps
`default_nettype none

module cise_alu
    import cise_pkg::*;
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] m,
    input  wire logic       cin,
    input  wire cise_alu_t  op,
    output logic      [7:0] res,
    output logic            n,
    output logic            z,
    output logic            c,
    output logic            c_wr
);

    always_comb begin
        res  = m;
        c    = cin;
        c_wr = 1'b1;
        case (op)
            ALU_PASS: begin
                c_wr = 1'b0;
            end
            ALU_OR: begin
                res  = a | m;
                c_wr = 1'b0;
            end
            ALU_NEG: begin
                res = 8'h00 - m;
                c   = |m;
            end
            ALU_LSL: begin
                res = {m[6:0], 1'b0};
                c   = m[7];
            end
            ALU_LSR: begin
                res = {1'b0, m[7:1]};
                c   = m[0];
            end
            ALU_ROL: begin
                res = {m[6:0], cin};
                c   = m[7];
            end
            ALU_ROR: begin
                res = {cin, m[7:1]};
                c   = m[0];
            end
            default: begin
                c_wr = 1'b0;
            end
        endcase
        n = res[7];
        z = (res == 8'h00);
    end

endmodule : cise_alu

`default_nettype wire

/* rtl/cise_exec.sv */
// Overview of operation
// - Call advances PC, pushes low then high byte, SP decrements each, then jumps.
// - PC advance before the call push equals instruction length, one to three.
// - Load accumulator copies operand; N and Z from result; carry kept.
// - Load accumulator opcodes A6, B6, C6, F6, E6, D6 with cycle counts.
// - Load index copies operand into index; N and Z updated; carry kept.
// - Shift left: bit 0 gets zero, carry gets old top bit.
// - Shift left opcodes 48, 58, 38, 78, 68.
// - Shift right: bit 7 gets zero, carry gets old bit 0.
// - Shift right opcodes 44, 54, 34, 74, 64.
// - Negate gives two's complement; 80 stays 80; N and Z follow.
// - Negate sets carry when operand was nonzero, else clears it.
// - Negate opcodes 40, 50, 30, 70, 60.
// - No-operation 9D only advances PC, one cycle.
// - Inclusive OR into accumulator; N and Z from result.
// - OR opcodes AA, BA, CA, FA, EA, DA with cycle counts.
// - Rotate left: bit 0 gets old carry, carry gets old top bit.
// - Rotate left opcodes 49, 59, 39, 79, 69.
// - Rotate right: bit 7 gets old carry.
// - Return pre-increments SP; pulls CC, A, X, PC high, PC low.
// - Interrupt mask ends clear only if the pulled mask bit is zero.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module cise_exec
    import cise_pkg::*;
#(
    parameter int              AW       = 12,
    parameter logic [AW-1:0]   PC_RESET = '0
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output logic      [AW-1:0] mem_addr,
    output logic               mem_rd,
    output logic               mem_wr,
    output logic      [7:0]    mem_wdata,
    input  wire logic [7:0]    mem_rdata
);

    cise_state_t     state;
    cise_state_t     ret_state;
    logic [7:0]      acc;
    logic [7:0]      idx;
    logic [7:0]      sp;
    logic [4:0]      cc;
    logic [AW-1:0]   pc;
    logic [7:0]      opc;
    logic [7:0]      b2;
    logic [7:0]      b3;
    logic [AW-1:0]   ea_q;
    logic [2:0]      pull_cnt;
    logic [2:0]      cyc_cnt;
    logic            run;
    logic            step_req;
    logic            err;

    // Bus side helpers
    logic            apb_wr;
    logic            start_ok;
    logic            err_clr;
    logic [15:0]     pc16;

    // Decode
    logic [7:0]      dec_opc;
    logic [3:0]      hi;
    logic [3:0]      lo;
    logic [1:0]      dec_bytes;
    logic            dec_rmw;
    logic            dec_mem;
    logic            dec_legal;
    logic            dec_jsr;
    logic            dec_rd;
    cise_alu_t       dec_alu;
    logic [15:0]     ea16;

    // ALU
    logic [7:0]      alu_m;
    logic [7:0]      alu_res;
    logic            alu_n;
    logic            alu_z;
    logic            alu_c;
    logic            alu_c_wr;

    assign apb_wr   = psel & penable & pwrite & pready;
    assign start_ok = (state == ST_IDLE) & (run | step_req) & ~err & ~apb_wr;
    assign err_clr  = apb_wr & (paddr == REG_STATUS) & pwdata[STAT_ERR_BIT];
    assign pc16     = 16'(pc);

    assign dec_opc = (state == ST_OPC) ? mem_rdata : opc;
    assign hi      = dec_opc[7:4];
    assign lo      = dec_opc[3:0];

    always_comb begin
        dec_rmw   = (hi >= M_RMW_DIR) && (hi <= M_RMW_IX) &&
                    (lo == F_NEG || lo == F_LSR || lo == F_ROR || lo == F_LSL || lo == F_ROL);
        dec_mem   = (hi >= M_IMM) &&
                    (lo == F_LDA || lo == F_ORA || lo == F_LDX || (lo == F_JSR && hi != M_IMM));
        dec_legal = dec_rmw | dec_mem | (dec_opc == OPC_RTI) |
                    (dec_opc == OPC_RSP) | (dec_opc == OPC_NOP);
        dec_jsr   = dec_mem && (lo == F_JSR);
        dec_rd    = (dec_rmw && hi != M_ACC && hi != M_IDX) || (dec_mem && !dec_jsr && hi != M_IMM);
        if (hi == M_EXT || hi == M_IX2)
            dec_bytes = 2'd2;
        else if (hi == M_RMW_DIR || hi == M_RMW_IX1 || hi == M_IMM || hi == M_DIR || hi == M_IX1)
            dec_bytes = 2'd1;
        else
            dec_bytes = 2'd0;
        case (lo)
            F_NEG:   dec_alu = dec_rmw ? ALU_NEG : ALU_PASS;
            F_LSR:   dec_alu = ALU_LSR;
            F_ROR:   dec_alu = dec_rmw ? ALU_ROR : ALU_PASS;
            F_LSL:   dec_alu = ALU_LSL;
            F_ROL:   dec_alu = ALU_ROL;
            F_ORA:   dec_alu = ALU_OR;
            default: dec_alu = ALU_PASS;
        endcase
    end

    // Effective address from registered operand bytes
    always_comb begin
        case (opc[7:4])
            M_RMW_DIR, M_DIR: ea16 = {8'h00, b2};
            M_EXT:            ea16 = {b2, b3};
            M_RMW_IX, M_IX:   ea16 = {8'h00, idx};
            M_RMW_IX1, M_IX1: ea16 = 16'(b2) + 16'(idx);
            M_IX2:            ea16 = {b2, b3} + 16'(idx);
            default:          ea16 = 16'h0000;
        endcase
    end

    always_comb begin
        if (state == ST_DATA)
            alu_m = mem_rdata;
        else if (hi == M_ACC)
            alu_m = acc;
        else if (hi == M_IDX)
            alu_m = idx;
        else
            alu_m = b2;
    end

    cise_alu u_alu (
        .a    (acc),
        .m    (alu_m),
        .cin  (cc[CC_C]),
        .op   (dec_alu),
        .res  (alu_res),
        .n    (alu_n),
        .z    (alu_z),
        .c    (alu_c),
        .c_wr (alu_c_wr)
    );

    // Instruction sequencer, CPU registers and memory port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            ret_state <= ST_IDLE;
            acc       <= 8'h00;
            idx       <= 8'h00;
            sp        <= SP_TOP;
            cc        <= CC_RST;
            pc        <= PC_RESET;
            opc       <= OPC_NOP;
            b2        <= 8'h00;
            b3        <= 8'h00;
            ea_q      <= '0;
            pull_cnt  <= 3'h0;
            cyc_cnt   <= 3'h0;
            err       <= 1'b0;
            mem_addr  <= '0;
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            if (cyc_cnt != 3'h7)
                cyc_cnt <= cyc_cnt + 3'h1;
            if (err_clr)
                err <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (apb_wr && paddr == REG_ACC)
                        acc <= pwdata[7:0];
                    else if (apb_wr && paddr == REG_IDX)
                        idx <= pwdata[7:0];
                    else if (apb_wr && paddr == REG_SP)
                        sp <= pwdata[7:0];
                    else if (apb_wr && paddr == REG_CC)
                        cc <= pwdata[4:0];
                    else if (apb_wr && paddr == REG_PC)
                        pc <= pwdata[AW-1:0];
                    if (start_ok)
                        state <= ST_FETCH;
                end
                ST_FETCH: begin
                    cyc_cnt   <= 3'h1;
                    mem_addr  <= pc;
                    mem_rd    <= 1'b1;
                    ret_state <= ST_OPC;
                    state     <= ST_RWAIT;
                end
                ST_RWAIT: begin
                    state <= ret_state;
                end
                ST_OPC: begin
                    opc <= mem_rdata;
                    if (!dec_legal) begin
                        err   <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        pc <= pc + 1'b1;
                        if (dec_bytes != 2'd0) begin
                            mem_addr  <= pc + 1'b1;
                            mem_rd    <= 1'b1;
                            ret_state <= ST_BYTE2;
                            state     <= ST_RWAIT;
                        end else begin
                            state <= ST_EXEC;
                        end
                    end
                end
                ST_BYTE2: begin
                    b2 <= mem_rdata;
                    pc <= pc + 1'b1;
                    if (dec_bytes == 2'd2) begin
                        mem_addr  <= pc + 1'b1;
                        mem_rd    <= 1'b1;
                        ret_state <= ST_BYTE3;
                        state     <= ST_RWAIT;
                    end else begin
                        state <= ST_EXEC;
                    end
                end
                ST_BYTE3: begin
                    b3    <= mem_rdata;
                    pc    <= pc + 1'b1;
                    state <= ST_EXEC;
                end
                ST_EXEC: begin
                    ea_q  <= AW'(ea16);
                    state <= ST_DONE;
                    if (opc == OPC_RSP) begin
                        sp <= SP_TOP;
                    end else if (opc == OPC_RTI) begin
                        sp        <= sp + 8'h01;
                        mem_addr  <= AW'(sp + 8'h01);
                        mem_rd    <= 1'b1;
                        pull_cnt  <= 3'h0;
                        ret_state <= ST_PULL;
                        state     <= ST_RWAIT;
                    end else if (dec_jsr) begin
                        mem_addr  <= AW'(sp);
                        mem_wdata <= pc16[7:0];
                        mem_wr    <= 1'b1;
                        sp        <= sp - 8'h01;
                        state     <= ST_PUSH_HI;
                    end else if (dec_rd) begin
                        mem_addr  <= AW'(ea16);
                        mem_rd    <= 1'b1;
                        ret_state <= ST_DATA;
                        state     <= ST_RWAIT;
                    end else if (opc != OPC_NOP) begin
                        // Register-only forms: accumulator, index, immediate
                        if (hi == M_IDX || (dec_mem && lo == F_LDX))
                            idx <= alu_res;
                        else
                            acc <= alu_res;
                        cc[CC_N] <= alu_n;
                        cc[CC_Z] <= alu_z;
                        if (alu_c_wr)
                            cc[CC_C] <= alu_c;
                    end
                end
                ST_DATA: begin
                    if (dec_rmw) begin
                        mem_addr  <= ea_q;
                        mem_wdata <= alu_res;
                        mem_wr    <= 1'b1;
                    end else if (lo == F_LDX) begin
                        idx <= alu_res;
                    end else begin
                        acc <= alu_res;
                    end
                    cc[CC_N] <= alu_n;
                    cc[CC_Z] <= alu_z;
                    if (alu_c_wr)
                        cc[CC_C] <= alu_c;
                    state <= ST_DONE;
                end
                ST_PUSH_HI: begin
                    mem_addr  <= AW'(sp);
                    mem_wdata <= pc16[15:8];
                    mem_wr    <= 1'b1;
                    sp        <= sp - 8'h01;
                    pc        <= ea_q;
                    state     <= ST_DONE;
                end
                ST_PULL: begin
                    case (pull_cnt)
                        3'h0:    cc  <= mem_rdata[4:0];
                        3'h1:    acc <= mem_rdata;
                        3'h2:    idx <= mem_rdata;
                        3'h3:    pc  <= AW'({mem_rdata, pc16[7:0]});
                        default: pc  <= AW'({pc16[15:8], mem_rdata});
                    endcase
                    if (pull_cnt == 3'h4) begin
                        state <= ST_DONE;
                    end else begin
                        pull_cnt  <= pull_cnt + 3'h1;
                        sp        <= sp + 8'h01;
                        mem_addr  <= AW'(sp + 8'h01);
                        mem_rd    <= 1'b1;
                        ret_state <= ST_PULL;
                        state     <= ST_RWAIT;
                    end
                end
                ST_DONE: begin
                    // Never finish faster than the documented count
                    if (cyc_cnt >= cise_cycles(opc))
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // APB slave: one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            if (paddr == REG_CTRL)
                prdata <= {30'h0, step_req, run};
            else if (paddr == REG_STATUS)
                prdata <= {16'h0, opc, 6'h0, err, (state != ST_IDLE)};
            else if (paddr == REG_ACC)
                prdata <= {24'h0, acc};
            else if (paddr == REG_IDX)
                prdata <= {24'h0, idx};
            else if (paddr == REG_SP)
                prdata <= {24'h0, sp};
            else if (paddr == REG_CC)
                prdata <= {27'h0, cc};
            else if (paddr == REG_PC)
                prdata <= {16'h0, pc16};
            else begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b1;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Run control; no step request is taken in the same cycle as a new write, so a pending one stays set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run      <= 1'b0;
            step_req <= 1'b0;
        end else begin
            if (apb_wr && paddr == REG_CTRL) begin
                run      <= pwdata[CTRL_RUN_BIT];
                step_req <= pwdata[CTRL_STEP_BIT] | (step_req & ~start_ok);
            end else if (start_ok) begin
                step_req <= 1'b0;
            end
        end
    end

endmodule : cise_exec

`default_nettype wire

/* verification/cise_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module cise_mem #(parameter int AW = 12) (
    input  wire logic [AW-1:0] mem_addr,
    input  wire logic          pclk,
    input  wire logic          mem_rd,
    input  wire logic          mem_wr,
    input  wire logic [7:0]    mem_wdata,
    output logic      [7:0]    mem_rdata
);
    logic [7:0] mem [2**AW];
    always @(posedge pclk) begin
        // Read data shows one cycle, then scrambles
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule : cise_mem
`default_nettype wire

/* verification/cise_exec_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module cise_exec_asserts #(parameter int AW = 12) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic [AW-1:0] mem_addr,
    input wire logic          mem_rd,
    input wire logic          mem_wr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_push; !mem_wr ##1 mem_wr ##1 mem_wr; endsequence
    property p_setup; psel && !penable |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    property p_rd; mem_rd |=> !mem_rd; endproperty
    property p_excl; !(mem_rd && mem_wr); endproperty
    property p_addr; $changed(mem_addr) |-> mem_rd || mem_wr; endproperty
    property p_push_pair; s_push |-> mem_addr == $past(mem_addr) - 1'b1; endproperty
    property p_push_stack; s_push |-> mem_addr[AW-1:8] == '0; endproperty
    a_setup:      assert property (p_setup) else $error("no ready after setup");
    a_pulse:      assert property (p_pulse) else $error("ready longer than one cycle");
    a_err:        assert property (p_err) else $error("bad error response");
    a_rd:         assert property (p_rd) else $error("reads too close");
    a_excl:       assert property (p_excl) else $error("read and write together");
    a_addr:       assert property (p_addr) else $error("address moved without request");
    a_push_pair:  assert property (p_push_pair) else $error("push order wrong");
    a_push_stack: assert property (p_push_stack) else $error("push outside stack");
endmodule : cise_exec_asserts
bind cise_exec cise_exec_asserts #(.AW(AW)) u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr));
`default_nettype wire

/* verification/cise_exec_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t %h", $time, g); end end
module cise_exec_test
    import cise_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, mem_rd, mem_wr, err;
    logic [11:0] paddr = '0, mem_addr;
    logic [31:0] pwdata = '0, prdata, q;
    logic [7:0]  mem_wdata, mem_rdata;
    int          mismatches = 0, check_count = 0;
    cise_exec #(.AW(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    cise_mem #(.AW(12)) MEM (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    initial begin
        forever #25 pclk = ~pclk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        `CHK(q, e)
    endtask : rchk
    // One instruction at 0x010 from the given registers
    task automatic run(input logic [7:0] o, b, a, cc);
        MEM.mem[16] = o;
        MEM.mem[17] = b;
        apb(1'b1, REG_ACC, {24'h0, a});
        apb(1'b1, REG_IDX, {24'h0, a});
        apb(1'b1, REG_CC, {24'h0, cc});
        apb(1'b1, REG_PC, 32'h10);
        apb(1'b1, REG_CTRL, 32'h2);
        do apb(1'b0, REG_STATUS, '0); while (q[STAT_BUSY_BIT] !== 1'b0);
    endtask : run
    task automatic t_shift;
        logic [3:0] f [5] = '{F_LSL, F_LSR, F_ROL, F_ROR, F_NEG};
        logic [7:0] r [5] = '{8'h00, 8'h40, 8'h01, 8'hc0, 8'h80};
        logic [7:0] c [5] = '{8'h1b, 8'h18, 8'h19, 8'h1c, 8'h1d};
        for (int i = 0; i < 10; i++) begin
            run({3'b010, i[0], f[i/2]}, 8'h0, 8'h80, 8'h19);
            rchk(i[0] ? REG_IDX : REG_ACC, {24'h0, r[i/2]});
            rchk(i[0] ? REG_ACC : REG_IDX, 32'h80);
            rchk(REG_CC, {24'h0, c[i/2]});
        end
        run(8'h40, 8'h0, 8'h00, 8'h09);
        rchk(REG_CC, 32'h0a);
    endtask : t_shift
    task automatic t_load;
        run(8'ha6, 8'h00, 8'h55, 8'h19);
        rchk(REG_CC, 32'h1b);
        run(8'haa, 8'h80, 8'h01, 8'h0a);
        rchk(REG_ACC, 32'h81);
        rchk(REG_CC, 32'h0c);
        MEM.mem[64] = 8'h00;
        run(8'hbe, 8'h40, 8'h77, 8'h0d);
        rchk(REG_IDX, 32'h0);
        rchk(REG_CC, 32'h0b);
        MEM.mem[64] = 8'hc1;
        run(8'h38, 8'h40, 8'h00, 8'h08);
        `CHK(MEM.mem[64], 8'h82)
        rchk(REG_CC, 32'h0d);
        MEM.mem[18] = 8'h44;
        MEM.mem[836] = 8'h7e;
        run(8'hc6, 8'h03, 8'h00, 8'h0e);
        rchk(REG_ACC, 32'h7e);
        rchk(REG_CC, 32'h08);
        MEM.mem[18] = 8'h34;
        MEM.mem[580] = 8'h01;
        run(8'hda, 8'h02, 8'h10, 8'h08);
        rchk(REG_ACC, 32'h11);
        run(8'had, 8'h00, 8'h00, 8'h08);
        rchk(REG_STATUS, 32'had02);
        apb(1'b1, REG_STATUS, 32'h2);
        rchk(REG_STATUS, 32'had00);
    endtask : t_load
    task automatic t_call;
        apb(1'b1, REG_SP, 32'h7f);
        run(8'hbd, 8'h30, 8'h00, 8'h08);
        `CHK({MEM.mem[127], MEM.mem[126]}, 16'h1200)
        rchk(REG_PC, 32'h30);
        rchk(REG_SP, 32'h7d);
        run(8'hfd, 8'h00, 8'h50, 8'h08);
        `CHK({MEM.mem[125], MEM.mem[124]}, 16'h1100)
        rchk(REG_PC, 32'h50);
        run(8'h9c, 8'h00, 8'h00, 8'h13);
        rchk(REG_SP, 32'h7f);
        rchk(REG_CC, 32'h13);
    endtask : t_call
    task automatic t_rti;
        apb(1'b1, REG_SP, 32'h70);
        {MEM.mem[113], MEM.mem[114], MEM.mem[115], MEM.mem[116], MEM.mem[117]} = 40'h0111220123;
        run(8'h80, 8'h00, 8'h00, 8'h08);
        rchk(REG_CC, 32'h01);
        rchk(REG_IDX, 32'h22);
        rchk(REG_PC, 32'h123);
        rchk(REG_SP, 32'h75);
        run(8'h9d, 8'h00, 8'h3c, 8'h15);
        rchk(REG_PC, 32'h11);
        rchk(REG_CC, 32'h15);
    endtask : t_rti
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(REG_SP, 32'h7f);
        apb(1'b0, 12'h100, '0);
        `CHK(err, 1'b1)
        t_shift();
        t_load();
        t_call();
        t_rti();
        finish_test();
    end
    initial begin
        repeat (30000) @(posedge pclk);
        mismatches++;
        finish_test();
    end
endmodule : cise_exec_test
`default_nettype wire
